// [hdl/drvpd_core.sv]
// Drive word interpreter, AHB-Lite slave
// Function
// - Layout 700 returns safety status 1b and the speed limit.
// - Safety words of layouts 700 and 701 are not failsafe.
// - Layout 701 returns 1b, 2b, the speed limit, then 3b.
// - Layout 750 takes add-in and limits and returns torque.
// - Received words act only with control bit 10 set.
// - Bit 0 low ramps down, then drops drive.
// - Rising bit 0 readies, and runs if bit 3 is set.
// - Bit 1 low drops drive at once to coast.
// - Bit 1 high leaves switch-on unblocked.
// - Status word one carries the drive state.
// - Bit 3 enables pulses, low drops drive at once.
// - Bit 5 lets the ramp follow, low freezes it in the run state only.
// - Bit 6 ramps to the setpoint, low brakes down.
`timescale 1ns/1ps
`default_nettype none
module drvpd_core
  import drvpd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_r,
  output logic hreadyout_r,
  output logic hresp_r,
  // Fieldbus receive words
  input wire logic pd_rx_valid,
  input wire logic [DRVPD_IDX_W-1:0] pd_rx_idx,
  input wire logic [DRVPD_WORD_W-1:0] pd_rx_word,
  input wire logic pd_cycle_end,
  // Fieldbus return words
  input wire logic pd_tx_rd,
  input wire logic [DRVPD_IDX_W-1:0] pd_tx_idx,
  output logic [DRVPD_WORD_W-1:0] pd_tx_word_r,
  // Motor side
  output logic pulse_enable_r,
  output logic signed [15:0] speed_out_r
);
  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] tel_base_r;
  logic [DRVPD_IDX_W-1:0] base_len_r;
  drvpd_layout_t layout_r;
  logic [15:0] ramp_up_r;
  logic [15:0] ramp_down_r;
  logic [15:0] setpoint_r;
  logic [15:0] ssw1b_r;
  logic [15:0] ssw2b_r;
  logic [15:0] ssw3b_r;
  logic [31:0] speed_limit_r;
  logic [15:0] torque_act_r;
  // Words taken from the fieldbus
  logic [15:0] cw_r;
  logic [15:0] scw1b_r;
  logic [15:0] scw3b_r;
  logic [15:0] addin_r;
  logic [15:0] lim_pos_r;
  logic [15:0] lim_neg_r;
  logic accepted_r;
  logic tel_fault_r;
  logic on_rise_r;
  // Unpack sequencer
  logic [2:0] seq_r;
  logic [15:0] stage_cw_r;
  logic [15:0] stage_a1_r;
  logic [15:0] stage_a2_r;
  logic [DRVPD_IDX_W-1:0] mem_rd_idx;
  logic [DRVPD_WORD_W-1:0] mem_rd_data;
  logic commit;
  // Drive state
  drvpd_state_t state_r;
  logic signed [15:0] ramp_value;
  logic ramp_at_zero;
  logic ramp_at_target;
  logic signed [15:0] ramp_target;
  logic [15:0] status_word;
  // Bus
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic aph_valid;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign aph_valid = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_r <= 1'b0;
      hresp_r <= 1'b0;
    end else if (ce) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else if (ce) begin
      dph_wr_r <= aph_valid && hwrite;
      dph_addr_r <= haddr[7:0];
    end
  end

  // Registered early so read data stand in the data phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (!aph_valid || hwrite) begin
        hrdata_r <= 32'h0000_0000;
      end else if (haddr[7:0] == DRVPD_OFF_CONFIG) begin
        hrdata_r <= {14'h0000, layout_r, 3'h0, base_len_r, tel_base_r};
      end else if (haddr[7:0] == DRVPD_OFF_RAMP_UP) begin
        hrdata_r <= {16'h0000, ramp_up_r};
      end else if (haddr[7:0] == DRVPD_OFF_RAMP_DOWN) begin
        hrdata_r <= {16'h0000, ramp_down_r};
      end else if (haddr[7:0] == DRVPD_OFF_SETPOINT) begin
        hrdata_r <= {16'h0000, setpoint_r};
      end else if (haddr[7:0] == DRVPD_OFF_SAFE_STAT_A) begin
        hrdata_r <= {ssw2b_r, ssw1b_r};
      end else if (haddr[7:0] == DRVPD_OFF_SAFE_STAT_B) begin
        hrdata_r <= {16'h0000, ssw3b_r};
      end else if (haddr[7:0] == DRVPD_OFF_SPEED_LIMIT) begin
        hrdata_r <= speed_limit_r;
      end else if (haddr[7:0] == DRVPD_OFF_TORQUE_ACT) begin
        hrdata_r <= {16'h0000, torque_act_r};
      end else if (haddr[7:0] == DRVPD_OFF_DRIVE_STAT) begin
        hrdata_r <= {ramp_value, 10'h000, tel_fault_r, accepted_r, pulse_enable_r,
                     1'b0, state_r};
      end else if (haddr[7:0] == DRVPD_OFF_CTRL_WORD) begin
        hrdata_r <= {status_word, cw_r};
      end else if (haddr[7:0] == DRVPD_OFF_SAFE_CTRL) begin
        hrdata_r <= {scw3b_r, scw1b_r};
      end else if (haddr[7:0] == DRVPD_OFF_TORQUE_ADDIN) begin
        hrdata_r <= {16'h0000, addin_r};
      end else if (haddr[7:0] == DRVPD_OFF_TORQUE_LIM) begin
        hrdata_r <= {lim_neg_r, lim_pos_r};
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tel_base_r <= 8'h01;
      base_len_r <= 5'h02;
      layout_r <= DRVPD_LAY_NONE;
      ramp_up_r <= DRVPD_RAMP_RESET;
      ramp_down_r <= DRVPD_RAMP_RESET;
      setpoint_r <= 16'h0000;
      ssw1b_r <= 16'h0000;
      ssw2b_r <= 16'h0000;
      ssw3b_r <= 16'h0000;
      speed_limit_r <= 32'h0000_0000;
      torque_act_r <= 16'h0000;
    end else if (ce && dph_wr_r) begin
      if (dph_addr_r == DRVPD_OFF_CONFIG) begin
        tel_base_r <= hwdata[7:0];
        base_len_r <= hwdata[DRVPD_CFG_BASE_LEN_LSB +: DRVPD_IDX_W];
        layout_r <= drvpd_layout_t'(hwdata[DRVPD_CFG_LAYOUT_LSB +: 2]);
      end else if (dph_addr_r == DRVPD_OFF_RAMP_UP) begin
        ramp_up_r <= hwdata[15:0];
      end else if (dph_addr_r == DRVPD_OFF_RAMP_DOWN) begin
        ramp_down_r <= hwdata[15:0];
      end else if (dph_addr_r == DRVPD_OFF_SETPOINT) begin
        setpoint_r <= hwdata[15:0];
      end else if (dph_addr_r == DRVPD_OFF_SAFE_STAT_A) begin
        ssw1b_r <= hwdata[15:0];
        ssw2b_r <= hwdata[31:16];
      end else if (dph_addr_r == DRVPD_OFF_SAFE_STAT_B) begin
        ssw3b_r <= hwdata[15:0];
      end else if (dph_addr_r == DRVPD_OFF_SPEED_LIMIT) begin
        speed_limit_r <= hwdata;
      end else if (dph_addr_r == DRVPD_OFF_TORQUE_ACT) begin
        torque_act_r <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and unpack sequencer
  // ----------------------------------------------------------------
  drvpd_word_mem u_rx_mem (
    .clk_sys(clk_sys),
    .ce(ce),
    .wr_en(pd_rx_valid),
    .wr_idx(pd_rx_idx),
    .wr_data(pd_rx_word),
    .rd_idx(mem_rd_idx),
    .rd_data_r(mem_rd_data)
  );

  // Step 1 fetches word 0, steps 2..4 fetch the first three appended words
  assign mem_rd_idx = (seq_r == 3'd1) ? 5'h00 :
                      base_len_r + DRVPD_IDX_W'(seq_r - 3'd2);
  assign commit = (seq_r == 3'd5);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= 3'd0;
      stage_cw_r <= 16'h0000;
      stage_a1_r <= 16'h0000;
      stage_a2_r <= 16'h0000;
    end else if (ce) begin
      if (seq_r == 3'd0) begin
        seq_r <= pd_cycle_end ? 3'd1 : 3'd0;
      end else if (commit) begin
        seq_r <= 3'd0;
      end else begin
        seq_r <= seq_r + 3'd1;
      end
      if (seq_r == 3'd2) begin
        stage_cw_r <= mem_rd_data;
      end
      if (seq_r == 3'd3) begin
        stage_a1_r <= mem_rd_data;
      end
      if (seq_r == 3'd4) begin
        stage_a2_r <= mem_rd_data;
      end
    end
  end

  // Unaccepted cycles leave held words alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cw_r <= 16'h0000;
      scw1b_r <= 16'h0000;
      scw3b_r <= 16'h0000;
      addin_r <= 16'h0000;
      lim_pos_r <= 16'h0000;
      lim_neg_r <= 16'h0000;
      accepted_r <= 1'b0;
      on_rise_r <= 1'b0;
    end else if (ce) begin
      on_rise_r <= 1'b0;
      if (commit) begin
        accepted_r <= stage_cw_r[DRVPD_CW_PLC_CTRL];
        if (stage_cw_r[DRVPD_CW_PLC_CTRL]) begin
          cw_r <= stage_cw_r;
          on_rise_r <= stage_cw_r[DRVPD_CW_ON] && !cw_r[DRVPD_CW_ON];
          if (layout_r == DRVPD_LAY_701) begin
            scw1b_r <= stage_a1_r;
            scw3b_r <= stage_a2_r;
          end else if (layout_r == DRVPD_LAY_750) begin
            addin_r <= stage_a1_r;
            lim_pos_r <= stage_a2_r;
            lim_neg_r <= mem_rd_data;
          end
        end
      end
    end
  end

  // Flags dropped ramp bits under the torque telegrams
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tel_fault_r <= 1'b0;
    end else if (ce && commit && stage_cw_r[DRVPD_CW_PLC_CTRL]) begin
      tel_fault_r <= ((tel_base_r == DRVPD_TEL_5) || (tel_base_r == DRVPD_TEL_6) ||
                      (tel_base_r == DRVPD_TEL_105) || (tel_base_r == DRVPD_TEL_106)) &&
                     !(stage_cw_r[DRVPD_CW_RAMP_NOT_ZERO] &&
                       stage_cw_r[DRVPD_CW_SETPOINT_EN]);
    end
  end

  // ----------------------------------------------------------------
  // Drive state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DRVPD_ST_INHIBIT;
    end else if (ce) begin
      if (!cw_r[DRVPD_CW_NO_COAST]) begin
        state_r <= DRVPD_ST_INHIBIT;
      end else begin
        case (state_r)
          DRVPD_ST_INHIBIT: begin
            if (on_rise_r) begin
              state_r <= cw_r[DRVPD_CW_ENABLE_OP] ? DRVPD_ST_RUN : DRVPD_ST_READY;
            end
          end
          DRVPD_ST_READY: begin
            if (!cw_r[DRVPD_CW_ON]) begin
              state_r <= DRVPD_ST_INHIBIT;
            end else if (cw_r[DRVPD_CW_ENABLE_OP]) begin
              state_r <= DRVPD_ST_RUN;
            end
          end
          DRVPD_ST_RUN: begin
            if (!cw_r[DRVPD_CW_ENABLE_OP]) begin
              state_r <= DRVPD_ST_READY;
            end else if (!cw_r[DRVPD_CW_ON]) begin
              state_r <= DRVPD_ST_RAMP_STOP;
            end
          end
          DRVPD_ST_RAMP_STOP: begin
            if (!cw_r[DRVPD_CW_ENABLE_OP] || ramp_at_zero) begin
              state_r <= DRVPD_ST_INHIBIT;
            end else if (on_rise_r) begin
              state_r <= DRVPD_ST_RUN;
            end
          end
          default: begin
            state_r <= DRVPD_ST_INHIBIT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_enable_r <= 1'b0;
    end else if (ce) begin
      pulse_enable_r <= (state_r == DRVPD_ST_RUN) || (state_r == DRVPD_ST_RAMP_STOP);
    end
  end

  // ----------------------------------------------------------------
  // Ramp generator
  // ----------------------------------------------------------------
  // Ramp stop ignores the setpoint so braking heads for zero
  assign ramp_target = ((state_r == DRVPD_ST_RUN) && cw_r[DRVPD_CW_SETPOINT_EN]) ?
                       signed'(setpoint_r) : 16'sd0;

  drvpd_ramp u_ramp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .force_zero(!pulse_enable_r || !cw_r[DRVPD_CW_RAMP_NOT_ZERO]),
    .hold(!cw_r[DRVPD_CW_RAMP_RUN] && (state_r == DRVPD_ST_RUN)),
    .target(ramp_target),
    .up_time(ramp_up_r),
    .down_time(ramp_down_r),
    .value_r(ramp_value),
    .at_zero(ramp_at_zero),
    .at_target(ramp_at_target)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_out_r <= 16'sd0;
    end else if (ce) begin
      speed_out_r <= ramp_value;
    end
  end

  // ----------------------------------------------------------------
  // Return telegram
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[DRVPD_SW_READY_ON] = (state_r != DRVPD_ST_INHIBIT);
    status_word[DRVPD_SW_READY] = (state_r != DRVPD_ST_INHIBIT);
    status_word[DRVPD_SW_OP_EN] = pulse_enable_r;
    status_word[DRVPD_SW_NO_COAST] = cw_r[DRVPD_CW_NO_COAST];
    status_word[DRVPD_SW_ON_INHIBIT] = (state_r == DRVPD_ST_INHIBIT);
    status_word[DRVPD_SW_AT_TARGET] = ramp_at_target;
    status_word[DRVPD_SW_CTRL_REQ] = accepted_r;
  end

  // Safety words are plain data; a failsafe
  // user needs a dedicated telegram
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_tx_word_r <= 16'h0000;
    end else if (ce && pd_tx_rd) begin
      pd_tx_word_r <= 16'h0000;
      if (pd_tx_idx == 5'h00) begin
        pd_tx_word_r <= status_word;
      end else if (pd_tx_idx == base_len_r) begin
        if (layout_r == DRVPD_LAY_700 || layout_r == DRVPD_LAY_701) begin
          pd_tx_word_r <= ssw1b_r;
        end else if (layout_r == DRVPD_LAY_750) begin
          pd_tx_word_r <= torque_act_r;
        end
      end else if (pd_tx_idx == base_len_r + 5'h01) begin
        if (layout_r == DRVPD_LAY_700) begin
          pd_tx_word_r <= speed_limit_r[31:16];
        end else if (layout_r == DRVPD_LAY_701) begin
          pd_tx_word_r <= ssw2b_r;
        end
      end else if (pd_tx_idx == base_len_r + 5'h02) begin
        if (layout_r == DRVPD_LAY_700) begin
          pd_tx_word_r <= speed_limit_r[15:0];
        end else if (layout_r == DRVPD_LAY_701) begin
          pd_tx_word_r <= speed_limit_r[31:16];
        end
      end else if (pd_tx_idx == base_len_r + 5'h03) begin
        if (layout_r == DRVPD_LAY_701) begin
          pd_tx_word_r <= speed_limit_r[15:0];
        end
      end else if (pd_tx_idx == base_len_r + 5'h04) begin
        if (layout_r == DRVPD_LAY_701) begin
          pd_tx_word_r <= ssw3b_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [include/drvpd_pkg.sv]
// Drive word interpreter constants
package drvpd_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DRVPD_OFF_CONFIG = 8'h00;
  localparam logic [7:0] DRVPD_OFF_RAMP_UP = 8'h04;
  localparam logic [7:0] DRVPD_OFF_RAMP_DOWN = 8'h08;
  localparam logic [7:0] DRVPD_OFF_SETPOINT = 8'h0c;
  localparam logic [7:0] DRVPD_OFF_SAFE_STAT_A = 8'h10;
  localparam logic [7:0] DRVPD_OFF_SAFE_STAT_B = 8'h14;
  localparam logic [7:0] DRVPD_OFF_SPEED_LIMIT = 8'h18;
  localparam logic [7:0] DRVPD_OFF_TORQUE_ACT = 8'h1c;
  localparam logic [7:0] DRVPD_OFF_DRIVE_STAT = 8'h20;
  localparam logic [7:0] DRVPD_OFF_CTRL_WORD = 8'h24;
  localparam logic [7:0] DRVPD_OFF_SAFE_CTRL = 8'h28;
  localparam logic [7:0] DRVPD_OFF_TORQUE_ADDIN = 8'h2c;
  localparam logic [7:0] DRVPD_OFF_TORQUE_LIM = 8'h30;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DRVPD_CFG_BASE_LEN_LSB = 8;
  localparam int DRVPD_CFG_LAYOUT_LSB = 16;
  localparam logic [15:0] DRVPD_RAMP_RESET = 16'h0010;
  localparam int DRVPD_WORD_W = 16;
  localparam int DRVPD_IDX_W = 5;
  localparam int DRVPD_DEPTH = 32;
  // Control word bit positions
  localparam int DRVPD_CW_ON = 0;
  localparam int DRVPD_CW_NO_COAST = 1;
  localparam int DRVPD_CW_ENABLE_OP = 3;
  localparam int DRVPD_CW_RAMP_NOT_ZERO = 4;
  localparam int DRVPD_CW_RAMP_RUN = 5;
  localparam int DRVPD_CW_SETPOINT_EN = 6;
  localparam int DRVPD_CW_PLC_CTRL = 10;
  // Status word bit positions
  localparam int DRVPD_SW_READY_ON = 0;
  localparam int DRVPD_SW_READY = 1;
  localparam int DRVPD_SW_OP_EN = 2;
  localparam int DRVPD_SW_NO_COAST = 4;
  localparam int DRVPD_SW_ON_INHIBIT = 6;
  localparam int DRVPD_SW_AT_TARGET = 8;
  localparam int DRVPD_SW_CTRL_REQ = 9;
  // Telegrams needing bits 4 and 6
  localparam logic [7:0] DRVPD_TEL_5 = 8'h05;
  localparam logic [7:0] DRVPD_TEL_6 = 8'h06;
  localparam logic [7:0] DRVPD_TEL_105 = 8'h69;
  localparam logic [7:0] DRVPD_TEL_106 = 8'h6a;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRVPD_LAY_NONE = 2'b00,
    DRVPD_LAY_700 = 2'b01,
    DRVPD_LAY_701 = 2'b10,
    DRVPD_LAY_750 = 2'b11
  } drvpd_layout_t;
  typedef enum logic [1:0] {
    DRVPD_ST_INHIBIT = 2'b00,
    DRVPD_ST_READY = 2'b01,
    DRVPD_ST_RUN = 2'b10,
    DRVPD_ST_RAMP_STOP = 2'b11
  } drvpd_state_t;
endpackage

// [hdl/drvpd_word_mem.sv]
// Receive word buffer
`timescale 1ns/1ps
`default_nettype none
module drvpd_word_mem
  import drvpd_pkg::*;
(
  // Clock and enable
  input wire logic clk_sys,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [DRVPD_IDX_W-1:0] wr_idx,
  input wire logic [DRVPD_WORD_W-1:0] wr_data,
  // Read port, data one cycle after the address
  input wire logic [DRVPD_IDX_W-1:0] rd_idx,
  output logic [DRVPD_WORD_W-1:0] rd_data_r
);
  logic [DRVPD_WORD_W-1:0] mem [DRVPD_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      rd_data_r <= mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

// [hdl/drvpd_ramp.sv]
// Speed ramp generator
`timescale 1ns/1ps
`default_nettype none
module drvpd_ramp
  import drvpd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic force_zero,
  input wire logic hold,
  input wire logic signed [15:0] target,
  input wire logic [15:0] up_time,
  input wire logic [15:0] down_time,
  // Output
  output logic signed [15:0] value_r,
  output logic at_zero,
  output logic at_target
);
  logic [15:0] tick_r;
  logic growing;
  logic [15:0] period;

  // Moving away from zero uses the up time, toward zero the down time
  assign growing = (target > value_r) ? (value_r >= 16'sd0) : (value_r <= 16'sd0);
  assign period = growing ? up_time : down_time;
  assign at_zero = (value_r == 16'sd0);
  assign at_target = (value_r == target);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= 16'sd0;
      tick_r <= 16'h0000;
    end else if (ce) begin
      if (force_zero) begin
        value_r <= 16'sd0;
        tick_r <= 16'h0000;
      end else if (!hold && !at_target) begin
        if (tick_r >= period) begin
          tick_r <= 16'h0000;
          value_r <= (target > value_r) ? value_r + 16'sd1 : value_r - 16'sd1;
        end else begin
          tick_r <= tick_r + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/drvpd_core_assertions.sv]
// Port checker for the word interpreter
`timescale 1ns/1ps
`default_nettype none
module drvpd_core_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata_r,
  input wire logic hreadyout_r,
  input wire logic hresp_r,
  // Fieldbus and motor
  input wire logic pd_rx_valid,
  input wire logic [4:0] pd_rx_idx,
  input wire logic [15:0] pd_rx_word,
  input wire logic pd_cycle_end,
  input wire logic pd_tx_rd,
  input wire logic [15:0] pd_tx_word_r,
  input wire logic pulse_enable_r,
  input wire logic signed [15:0] speed_out_r
);
  logic [15:0] cw_r;
  logic [15:0] acc_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------
  // Last control word written, last one accepted
  // ------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cw_r <= 16'h0000;
    end else if (ce && pd_rx_valid && pd_rx_idx == 5'h00) begin
      cw_r <= pd_rx_word;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 16'h0000;
    end else if (ce && pd_cycle_end && cw_r[10]) begin
      acc_r <= cw_r;
    end
  end
  sequence s_acc; pd_cycle_end && cw_r[10]; endsequence
  sequence s_rej; pd_cycle_end && !cw_r[10]; endsequence
  property p_resp; hresp_r == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("hresp");
  property p_ready; hreadyout_r |=> hreadyout_r; endproperty
  a_ready: assert property (p_ready) else $error("stall");
  property p_rd_idle; !(hsel && hready && htrans[1] && !hwrite) |=> hrdata_r == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_coast; s_acc ##0 !cw_r[1] |-> ##8 !pulse_enable_r [*2]; endproperty
  a_coast: assert property (p_coast) else $error("coast drive");
  property p_coast_speed; s_acc ##0 !cw_r[1] |-> ##[1:10] speed_out_r == 16'sh0; endproperty
  a_coast_speed: assert property (p_coast_speed) else $error("coast speed");
  property p_op_off; s_acc ##0 !cw_r[3] |-> ##8 !pulse_enable_r; endproperty
  a_op_off: assert property (p_op_off) else $error("op inhibit");
  property p_reject; s_rej |=> $stable(pulse_enable_r) [*8]; endproperty
  a_reject: assert property (p_reject) else $error("reject");
  property p_pulse_cause; $rose(pulse_enable_r) |-> acc_r[0] && acc_r[1] && acc_r[3]; endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("drive cause");
  property p_tx_hold; !pd_tx_rd && ce |=> $stable(pd_tx_word_r); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx hold");
  property p_step; $changed(speed_out_r) |-> speed_out_r == 16'sh0 ||
    16'(speed_out_r - $past(speed_out_r)) inside {16'h0001, 16'hffff}; endproperty
  a_step: assert property (p_step) else $error("ramp jump");
endmodule
bind drvpd_core drvpd_core_assertions u_chk (.clk_sys, .rst_n, .ce, .hsel, .htrans, .hwrite,
  .hready, .hrdata_r, .hreadyout_r, .hresp_r, .pd_rx_valid, .pd_rx_idx, .pd_rx_word,
  .pd_cycle_end, .pd_tx_rd, .pd_tx_word_r, .pulse_enable_r, .speed_out_r);
`default_nettype wire

// [testbench/drvpd_ctrl_model.sv]
// Fieldbus controller model
`timescale 1ns/1ps
`default_nettype none
module drvpd_ctrl_model
  import drvpd_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Words toward the block
  output logic pd_rx_valid,
  output logic [DRVPD_IDX_W-1:0] pd_rx_idx,
  output logic [DRVPD_WORD_W-1:0] pd_rx_word,
  output logic pd_cycle_end,
  // Return words
  output logic pd_tx_rd,
  output logic [DRVPD_IDX_W-1:0] pd_tx_idx,
  input wire logic [DRVPD_WORD_W-1:0] pd_tx_word_r
);
  initial begin
    pd_rx_valid = 1'b0;
    pd_rx_idx = 5'h00;
    pd_rx_word = 16'h0000;
    pd_cycle_end = 1'b0;
    pd_tx_rd = 1'b0;
    pd_tx_idx = 5'h00;
  end
  task automatic put(input logic [4:0] i, input logic [15:0] w);
    pd_rx_valid <= 1'b1;
    pd_rx_idx <= i;
    pd_rx_word <= w;
    @(posedge clk_sys);
  endtask
  // Appended words follow the two base words
  task automatic send(input logic [15:0] cw, input logic [15:0] a, b, c);
    put(5'h00, cw | 16'h0050);
    put(5'h02, a);
    put(5'h03, b);
    put(5'h04, c);
    pd_rx_valid <= 1'b0;
    pd_rx_word <= ~c;
    pd_cycle_end <= 1'b1;
    @(posedge clk_sys);
    pd_cycle_end <= 1'b0;
    repeat (9) @(posedge clk_sys);
  endtask
  task automatic fetch(input logic [4:0] i, output logic [15:0] w);
    pd_tx_rd <= 1'b1;
    pd_tx_idx <= i;
    @(posedge clk_sys);
    pd_tx_rd <= 1'b0;
    pd_tx_idx <= ~i;
    @(posedge clk_sys);
    w = pd_tx_word_r;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Bench for the word interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drvpd_pkg::*;
  logic clk_sys, rst_n, ce, hsel, hwrite, hreadyout_r, hresp_r, pulse_enable_r;
  logic pd_rx_valid, pd_cycle_end, pd_tx_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata_r, q;
  logic [4:0] pd_rx_idx, pd_tx_idx;
  logic [15:0] pd_rx_word, pd_tx_word_r, t;
  logic signed [15:0] speed_out_r;
  int n_fail, samples_checked;
  drvpd_core uut (.clk_sys, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout_r), .hrdata_r, .hreadyout_r, .hresp_r, .pd_rx_valid, .pd_rx_idx,
    .pd_rx_word, .pd_cycle_end, .pd_tx_rd, .pd_tx_idx, .pd_tx_word_r, .pulse_enable_r,
    .speed_out_r);
  drvpd_ctrl_model m (.clk_sys, .pd_rx_valid, .pd_rx_idx, .pd_rx_word, .pd_cycle_end,
    .pd_tx_rd, .pd_tx_idx, .pd_tx_word_r);
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout_r !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout_r !== 1'b1) @(posedge clk_sys);
    q = hrdata_r;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("reg", q, e);
  endtask
  task automatic tx(input logic [4:0] i, input logic [15:0] e);
    m.fetch(i, t);
    chk("tx", {16'h0000, t}, {16'h0000, e});
  endtask
  task automatic on_seq();
    m.send(16'h047e, 16'h0, 16'h0, 16'h0);
    m.send(16'h047f, 16'h0, 16'h0, 16'h0);
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_regs();
    rd(DRVPD_OFF_CONFIG, 32'h0000_0201);
    rd(DRVPD_OFF_RAMP_UP, 32'h0000_0010);
    rd(8'h40, 32'h0);
    ahb(1'b1, DRVPD_OFF_DRIVE_STAT, 32'hffff_ffff);
    rd(DRVPD_OFF_DRIVE_STAT, 32'h0);
    ahb(1'b1, DRVPD_OFF_RAMP_UP, 32'h0);
    ahb(1'b1, DRVPD_OFF_RAMP_DOWN, 32'h0);
    ahb(1'b1, DRVPD_OFF_SETPOINT, 32'h0000_0005);
  endtask
  task automatic t_drive();
    on_seq();
    chk("drive on", {31'h0, pulse_enable_r}, 32'h1);
    repeat (12) @(posedge clk_sys);
    chk("speed", {16'h0, speed_out_r}, 32'h5);
    m.fetch(5'h00, t);
    chk("status", {16'h0, t & 16'h0014}, 32'h14);
    m.send(16'h007d, 16'h0, 16'h0, 16'h0);
    chk("ignored", {31'h0, pulse_enable_r}, 32'h1);
    ahb(1'b0, DRVPD_OFF_DRIVE_STAT, 32'h0);
    chk("accepted", {31'h0, q[4]}, 32'h0);
    m.send(16'h0476, 16'h0, 16'h0, 16'h0);
    chk("op inhibit", {31'h0, pulse_enable_r}, 32'h0);
    on_seq();
    m.send(16'h047e, 16'h0, 16'h0, 16'h0);
    repeat (10) @(posedge clk_sys);
    chk("ramp stop", {15'h0, pulse_enable_r, speed_out_r}, 32'h0);
    on_seq();
    m.send(16'h047d, 16'h0, 16'h0, 16'h0);
    @(posedge clk_sys);
    chk("coast", {15'h0, pulse_enable_r, speed_out_r}, 32'h0);
  endtask
  task automatic t_layouts();
    ahb(1'b1, DRVPD_OFF_SAFE_STAT_A, 32'hb2b2_a1a1);
    ahb(1'b1, DRVPD_OFF_SAFE_STAT_B, 32'h0000_c3c3);
    ahb(1'b1, DRVPD_OFF_SPEED_LIMIT, 32'h1234_5678);
    ahb(1'b1, DRVPD_OFF_TORQUE_ACT, 32'h0000_7e7e);
    ahb(1'b1, DRVPD_OFF_CONFIG, 32'h0001_0201);
    tx(5'h02, 16'ha1a1);
    tx(5'h03, 16'h1234);
    tx(5'h04, 16'h5678);
    ahb(1'b1, DRVPD_OFF_CONFIG, 32'h0002_0201);
    m.send(16'h047d, 16'h5a01, 16'h5a03, 16'h0);
    rd(DRVPD_OFF_SAFE_CTRL, 32'h5a03_5a01);
    tx(5'h02, 16'ha1a1);
    tx(5'h03, 16'hb2b2);
    tx(5'h05, 16'h5678);
    tx(5'h06, 16'hc3c3);
    ahb(1'b1, DRVPD_OFF_CONFIG, 32'h0003_0201);
    m.send(16'h047d, 16'h0101, 16'h0202, 16'h0303);
    rd(DRVPD_OFF_TORQUE_ADDIN, 32'h0000_0101);
    rd(DRVPD_OFF_TORQUE_LIM, 32'h0303_0202);
    tx(5'h02, 16'h7e7e);
    tx(5'h03, 16'h0000);
  endtask
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #60000;
    n_fail++;
    results();
  end
  initial begin
    {rst_n, ce, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_drive();
    t_layouts();
    results();
  end
endmodule
`default_nettype wire
